//--- rtl/l2se_params.svh
// Purpose: constants of the layer-2 search engine
// Assumes: 100 MHz clock
// Notes:   aging interval counts whole units of AGE_UNIT_S seconds
`ifndef L2SE_PARAMS_SVH
`define L2SE_PARAMS_SVH
`define L2SE_AGE_LO_ADDR 12'h400
`define L2SE_AGE_HI_ADDR 12'h401
`define L2SE_AGE_LO_RST 8'h2c
`define L2SE_AGE_HI_RST 8'h01
`define L2SE_AGE_UNIT_S 1
`define L2SE_CLK_MHZ 100
`define L2SE_NE 4096
`define L2SE_CPU_PORT 4'h9
`define L2SE_TPID 16'h8100
`define L2SE_DEF_VID 12'h001
`define L2SE_BCAST 48'hffffffffffff
`define L2SE_IPMC_OUI 24'h01005e
`define L2SE_Q_FULL 4'hf
`endif

//--- rtl/l2se_pkg.sv
// Purpose: types of the layer-2 search engine
// Assumes: nothing
// Notes:   entries below index 2048 are chain heads
package l2se_pkg;
  typedef enum logic [2:0] {K_DYN, K_STATIC, K_SFILT, K_DFILT,
                            K_IPMC, K_BFILT, K_SECURE, K_MCAST} l2se_kind_t;
  typedef enum logic [2:0] {S_IDLE = 3'b000, S_SRC = 3'b001, S_DST = 3'b011,
                            S_LEARN = 3'b010, S_RESP = 3'b110} l2se_state_t;
  typedef struct packed {
    logic        valid;
    logic        linked;
    logic        age;
    logic        has_next;
    logic [10:0] next;
    logic [47:0] mac;
    logic [9:0]  ports;
    logic        trunk;
    l2se_kind_t  kind;
  } l2se_entry_t;
  typedef struct packed {
    logic [9:0] dest;
    logic       discard;
    logic       unicast;
    logic       flood;
    logic       trunk;
    logic [2:0] trunk_no;
    logic [1:0] cls4;
    logic       cls2;
    logic       drop_prec;
  } l2se_rsp_t;
  typedef struct packed {
    logic        del;
    logic [47:0] mac;
    logic [9:0]  ports;
  } l2se_msg_t;
  typedef struct packed {
    logic        en;
    logic        drop;
    logic [15:0] val;
  } l2se_flt_t;
  typedef struct packed {
    logic        en;
    logic        drop;
    logic [15:0] lo;
    logic [15:0] hi;
  } l2se_rng_t;
endpackage

//--- rtl/l2se_top.sv
// Purpose: layer-2 search engine: lookup, learning, aging, filters, CPU queues
// Assumes: l2se_pkg, l2se_params.svh; frame engine takes every response
// Notes:   learning writes the entry and the chain tail in one cycle; chains grow into on-chip entries
`timescale 1ns/100ps
`include "l2se_params.svh"
module l2se_top #(
  parameter int AGE_UNIT_CYC = `L2SE_AGE_UNIT_S * `L2SE_CLK_MHZ * 1000000
) (
  // clock and reset
  input  logic                        CLK,
  input  logic                        RESETN,
  // switch request and response
  input  logic                        REQ_VALID,
  input  logic [511:0]                REQ_DATA,
  input  logic [3:0]                  REQ_SRC,
  input  logic [9:0]                  REQ_CPU_DEST,
  output logic                        REQ_READY,
  output logic                        RSP_VALID,
  output l2se_pkg::l2se_rsp_t         RSP,
  // CPU messages and CPU port queues
  input  logic                        CPU_REPORT_EN,
  input  logic                        CPU_MSG_READY,
  output logic                        CPU_MSG_VALID,
  output l2se_pkg::l2se_msg_t         CPU_MSG,
  input  logic                        CPU_POP,
  output logic                        CPU_Q_VALID,
  output logic [1:0]                  CPU_Q_SEL,
  // register and table access
  input  logic                        CFG_WE,
  input  logic [11:0]                 CFG_ADDR,
  input  logic [7:0]                  CFG_WDATA,
  output logic [7:0]                  CFG_RDATA,
  input  logic                        MAC_WE,
  input  logic [11:0]                 MAC_IDX,
  input  l2se_pkg::l2se_entry_t       MAC_ENTRY,
  input  logic                        VLAN_WE,
  input  logic [11:0]                 VLAN_WID,
  input  logic [9:0]                  VLAN_WMEM,
  input  logic [3:0]                  VLAN_WFLT,
  // static configuration
  input  logic                        TAG_MODE,
  input  logic                        PROT_EN,
  input  logic [9:0]                  PROT_PORTS,
  input  logic [9:0][9:0]             PORT_MAP,
  input  logic [7:0][3:0][3:0]        TRUNK_MAP,
  input  l2se_pkg::l2se_flt_t [7:0]   PROTO_FLT,
  input  l2se_pkg::l2se_flt_t [7:0]   LPORT_FLT,
  input  l2se_pkg::l2se_rng_t         LPORT_RNG
);
  l2se_pkg::l2se_entry_t tbl [`L2SE_NE];
  logic [9:0]            vmem [`L2SE_NE];
  logic [3:0]            vflt [`L2SE_NE];
  l2se_pkg::l2se_state_t state;
  l2se_pkg::l2se_entry_t e, a, s_ent, d_ent;
  l2se_pkg::l2se_rsp_t   next_rsp;
  logic [47:0]           da, sa;
  logic [11:0]           vid, cur, hole, tail, sidx, free_slot, scan_idx, lidx;
  logic [2:0]            pri;
  logic [15:0]           etype, lport;
  logic [3:0]            src;
  logic [9:0]            cdest;
  logic [7:0]            age_lo, age_hi, pm, lm;
  logic [26:0]           unit_cnt;
  logic [15:0]           ival_cnt;
  logic [3:0]            cq [4];
  logic [3:0]            next_cq [4];
  logic [1:0]            next_sel;
  logic                  next_qv, tg, mc, bc, ipmc, hit, walk_end, need_learn;
  logic                  hole_v, free_v, s_hit, d_hit, scan_on, scan_go;
  logic                  aged, busy, del, lrn_go, lrn_ok, rm;

  function automatic logic [9:0] oh(input logic [3:0] p);
    oh = 10'h001 << p;
  endfunction
  function automatic logic [10:0] hsh(input logic [47:0] m);
    hsh = m[10:0] ^ m[21:11] ^ m[32:22] ^ m[43:33] ^ {7'h00, m[47:44]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // request decode and walk helpers
  assign tg = REQ_DATA[415:400] == `L2SE_TPID;
  assign mc = da[40];
  assign bc = da == `L2SE_BCAST;
  assign ipmc = da[47:24] == `L2SE_IPMC_OUI;
  assign e = tbl[cur];
  assign hit = e.valid && e.mac == ((state == l2se_pkg::S_SRC) ? sa : da);
  assign walk_end = hit || !e.has_next;
  assign a = tbl[scan_idx];
  assign busy = CPU_REPORT_EN && CPU_MSG_VALID;
  assign scan_go = state == l2se_pkg::S_IDLE && scan_on && !REQ_VALID && !MAC_WE;
  assign aged = a.valid && !a.age && a.kind == l2se_pkg::K_DYN;
  assign del = aged && !busy;
  assign need_learn = !sa[40] && (!s_hit ||
                      (s_ent.kind == l2se_pkg::K_DYN && s_ent.ports != oh(src)));
  assign lidx = s_hit ? sidx : (hole_v ? hole : free_slot);
  assign lrn_ok = s_hit || hole_v || free_v;
  assign lrn_go = state == l2se_pkg::S_LEARN && !busy;

  // protocol and logical port matches, one per filter slot
  for (genvar g = 0; g < 8; g++) begin : g_flt
    assign pm[g] = PROTO_FLT[g].en && PROTO_FLT[g].drop && PROTO_FLT[g].val == etype;
    assign lm[g] = LPORT_FLT[g].en && LPORT_FLT[g].drop && LPORT_FLT[g].val == lport;
  end
  assign rm = LPORT_RNG.en && LPORT_RNG.drop && lport >= LPORT_RNG.lo &&
              lport <= LPORT_RNG.hi;

  //////////////////////////////////////////////////////////////////////////////
  // address table writes: CPU, aging scan, refresh, learning
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < `L2SE_NE; i++) begin
        tbl[i] <= '0;
      end
    end else if (state == l2se_pkg::S_IDLE && MAC_WE) begin
      tbl[MAC_IDX] <= MAC_ENTRY;
    end else if (scan_go) begin
      if (del) begin
        tbl[scan_idx].valid <= 1'b0;
      end else begin
        tbl[scan_idx].age <= 1'b0;
      end
    end else if (state == l2se_pkg::S_SRC && hit) begin
      tbl[cur].age <= 1'b1;
    end else if (lrn_go && lrn_ok) begin
      tbl[lidx] <= '{valid: 1'b1, linked: 1'b1, age: 1'b1,
                     has_next: tbl[lidx].has_next, next: tbl[lidx].next,
                     mac: sa, ports: oh(src), trunk: 1'b0,
                     kind: l2se_pkg::K_DYN};
      if (!s_hit && !hole_v) begin
        tbl[tail].has_next <= 1'b1;
        tbl[tail].next <= free_slot[10:0];
      end
    end
  end

  // VLAN membership and per-VLAN flood filters
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < `L2SE_NE; i++) begin
        vmem[i] <= '0;
        vflt[i] <= '0;
      end
    end else if (VLAN_WE) begin
      vmem[VLAN_WID] <= VLAN_WMEM;
      vflt[VLAN_WID] <= VLAN_WFLT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // search state machine: source walk, destination walk, learn, respond
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= l2se_pkg::S_IDLE;
      REQ_READY <= 1'b1;
      {da, sa, vid, pri, etype, lport, src, cdest} <= '0;
      {cur, hole, tail, sidx, hole_v, s_hit, d_hit} <= '0;
      s_ent <= '0;
      d_ent <= '0;
    end else begin
      case (state)
        l2se_pkg::S_IDLE: begin
          if (REQ_VALID) begin
            REQ_READY <= 1'b0;
            da <= REQ_DATA[511:464];
            sa <= REQ_DATA[463:416];
            vid <= tg ? REQ_DATA[395:384] : `L2SE_DEF_VID;
            pri <= tg ? REQ_DATA[399:397] : 3'h0;
            etype <= tg ? REQ_DATA[383:368] : REQ_DATA[415:400];
            lport <= tg ? REQ_DATA[191:176] : REQ_DATA[223:208];
            src <= REQ_SRC;
            cdest <= REQ_CPU_DEST;
            cur <= {1'b0, hsh(REQ_DATA[463:416])};
            {hole_v, s_hit, d_hit} <= 3'h0;
            state <= l2se_pkg::S_SRC;
          end
        end
        l2se_pkg::S_SRC: begin
          if (!e.valid && !hole_v) begin
            hole_v <= 1'b1;
            hole <= cur;
          end
          if (hit) begin
            s_hit <= 1'b1;
            sidx <= cur;
            s_ent <= e;
          end
          if (walk_end) begin
            tail <= cur;
            cur <= {1'b0, hsh(da)};
            state <= l2se_pkg::S_DST;
          end else begin
            cur <= {1'b1, e.next};
          end
        end
        l2se_pkg::S_DST: begin
          if (hit) begin
            d_hit <= 1'b1;
            d_ent <= e;
          end
          if (walk_end) begin
            state <= need_learn ? l2se_pkg::S_LEARN : l2se_pkg::S_RESP;
          end else begin
            cur <= {1'b1, e.next};
          end
        end
        l2se_pkg::S_LEARN: begin
          if (lrn_go) begin
            state <= l2se_pkg::S_RESP;
          end
        end
        l2se_pkg::S_RESP: begin
          state <= l2se_pkg::S_IDLE;
          REQ_READY <= 1'b1;
        end
        default: begin
          state <= l2se_pkg::S_IDLE;
          REQ_READY <= 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // forwarding decision
  always_comb begin
    logic [9:0] vm;
    logic [9:0] tgt;
    logic [9:0] d;
    logic [3:0] fl;
    d = 10'h000;
    vm = TAG_MODE ? vmem[vid] : PORT_MAP[src];
    tgt = d_ent.trunk ? oh(TRUNK_MAP[d_ent.ports[2:0]][sa[1:0] ^ da[1:0]])
                      : d_ent.ports;
    fl = vflt[vid];
    if (src == `L2SE_CPU_PORT) begin
      d = cdest;
    end else if (!mc && d_hit) begin
      d = (!TAG_MODE || |(tgt & vm)) ? (tgt & vm) : vm;
    end else begin
      d = vm;
    end
    d = d & ~oh(src);
    if (PROT_EN && PROT_PORTS[src]) begin
      d = d & ~PROT_PORTS;
    end
    next_rsp.discard = (s_hit && (s_ent.kind == l2se_pkg::K_SFILT ||
                                  s_ent.kind == l2se_pkg::K_BFILT)) ||
                       (d_hit && (d_ent.kind == l2se_pkg::K_DFILT ||
                                  d_ent.kind == l2se_pkg::K_BFILT)) ||
                       |pm || |lm || rm ||
                       (bc && fl[0]) || (!mc && !d_hit && fl[1]) ||
                       (mc && !bc && !ipmc && !d_hit && fl[2]) ||
                       (ipmc && !d_hit && fl[3]);
    next_rsp.dest = next_rsp.discard ? 10'h000 : d;
    next_rsp.unicast = !mc;
    next_rsp.flood = !(d_hit && !mc) && src != `L2SE_CPU_PORT;
    next_rsp.trunk = d_hit && !mc && d_ent.trunk;
    next_rsp.trunk_no = d_ent.ports[2:0];
    next_rsp.cls4 = pri[2:1];
    next_rsp.cls2 = pri[2];
    next_rsp.drop_prec = ~pri[0];
  end

  // response register, one pulse per request
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RSP_VALID <= 1'b0;
      RSP <= '0;
    end else begin
      RSP_VALID <= state == l2se_pkg::S_RESP;
      if (state == l2se_pkg::S_RESP) begin
        RSP <= next_rsp;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // learn and delete messages toward the CPU
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CPU_MSG_VALID <= 1'b0;
      CPU_MSG <= '0;
    end else begin
      if (CPU_MSG_READY) begin
        CPU_MSG_VALID <= 1'b0;
      end
      if (CPU_REPORT_EN && lrn_go && lrn_ok) begin
        CPU_MSG_VALID <= 1'b1;
        CPU_MSG <= '{del: 1'b0, mac: sa, ports: oh(src)};
      end else if (CPU_REPORT_EN && scan_go && del) begin
        CPU_MSG_VALID <= 1'b1;
        CPU_MSG <= '{del: 1'b1, mac: a.mac, ports: a.ports};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // CPU port queue counts and strict priority pick
  always_comb begin
    next_qv = 1'b0;
    next_sel = 2'h0;
    for (int q = 0; q < 4; q++) begin
      next_cq[q] = cq[q];
      if (CPU_POP && CPU_Q_VALID && CPU_Q_SEL == 2'(q)) begin
        next_cq[q] = next_cq[q] - 4'h1;
      end
      if (RSP_VALID && RSP.dest[`L2SE_CPU_PORT] && RSP.cls4 == 2'(q) &&
          next_cq[q] != `L2SE_Q_FULL) begin
        next_cq[q] = next_cq[q] + 4'h1;
      end
      if (next_cq[q] != 4'h0) begin
        next_qv = 1'b1;
        next_sel = 2'(q);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int q = 0; q < 4; q++) begin
        cq[q] <= 4'h0;
      end
      CPU_Q_VALID <= 1'b0;
      CPU_Q_SEL <= 2'h0;
    end else begin
      cq <= next_cq;
      CPU_Q_VALID <= next_qv;
      CPU_Q_SEL <= next_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // aging registers, interval timer and scan pointer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      age_lo <= `L2SE_AGE_LO_RST;
      age_hi <= `L2SE_AGE_HI_RST;
      CFG_RDATA <= 8'h00;
      unit_cnt <= '0;
      ival_cnt <= '0;
      {scan_on, scan_idx, free_v, free_slot} <= '0;
    end else begin
      if (CFG_WE && CFG_ADDR == `L2SE_AGE_LO_ADDR) age_lo <= CFG_WDATA;
      if (CFG_WE && CFG_ADDR == `L2SE_AGE_HI_ADDR) age_hi <= CFG_WDATA;
      CFG_RDATA <= (CFG_ADDR == `L2SE_AGE_LO_ADDR) ? age_lo :
                   (CFG_ADDR == `L2SE_AGE_HI_ADDR) ? age_hi : 8'h00;
      if (lrn_go && !s_hit && !hole_v) free_v <= 1'b0;
      if (scan_go && !(aged && busy)) begin
        scan_idx <= scan_idx + 12'h001;
        if (scan_idx == 12'hfff) scan_on <= 1'b0;
        if (scan_idx[11] && !a.linked) begin
          free_v <= 1'b1;
          free_slot <= scan_idx;
        end
      end
      if (unit_cnt == 27'(AGE_UNIT_CYC - 1)) begin
        unit_cnt <= '0;
        if ({age_hi, age_lo} == 16'h0000) begin
          ival_cnt <= '0;
        end else if (ival_cnt >= {age_hi, age_lo} - 16'h0001) begin
          ival_cnt <= '0;
          scan_on <= 1'b1;
          scan_idx <= '0;
        end else begin
          ival_cnt <= ival_cnt + 16'h0001;
        end
      end else begin
        unit_cnt <= unit_cnt + 27'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_resp_pulse: assert property (state == l2se_pkg::S_RESP |=> RSP_VALID ##1 !RSP_VALID)
    else $error("response not a single pulse");
  a_learn_wait: assert property (state == l2se_pkg::S_LEARN && busy |=> state == l2se_pkg::S_LEARN)
    else $error("learn did not wait for message space");
  a_learn_msg: assert property (CPU_REPORT_EN && lrn_go && lrn_ok |=> CPU_MSG_VALID && !CPU_MSG.del && CPU_MSG.mac == $past(sa))
    else $error("learn message missing");
  a_age_refresh: assert property (state == l2se_pkg::S_SRC && hit |=> tbl[$past(cur)].age)
    else $error("source hit did not refresh age");
  a_age_static: assert property (scan_go && a.kind != l2se_pkg::K_DYN |=> tbl[$past(scan_idx)].valid == $past(a.valid))
    else $error("non-dynamic entry aged out");
  a_age_delete: assert property (scan_go && del |=> !tbl[$past(scan_idx)].valid ##0 (CPU_MSG_VALID || !$past(CPU_REPORT_EN)))
    else $error("aged entry not removed or not reported");
  a_cpu_strict: assert property (CPU_Q_VALID && CPU_Q_SEL != 2'h3 |-> cq[3] == 4'h0)
    else $error("lower CPU queue served before a higher one");
  a_prot_final: assert property (RSP_VALID && $past(PROT_EN && PROT_PORTS[src]) |-> (RSP.dest & $past(PROT_PORTS)) == 10'h000)
    else $error("protected port forwarded to protected port");
  a_cpu_egress: assert property (RSP_VALID && $past(src) == `L2SE_CPU_PORT && !RSP.discard && !$past(PROT_EN) |-> RSP.dest == ($past(cdest) & ~oh(`L2SE_CPU_PORT)))
    else $error("CPU frame egress differs from requested ports");

  c_learn: cover property (lrn_go && lrn_ok && !s_hit);
  c_delete: cover property (scan_go && del && CPU_REPORT_EN);
  c_trunk: cover property (RSP_VALID && RSP.trunk);
  c_cpu_pop: cover property (CPU_POP && CPU_Q_VALID && CPU_Q_SEL == 2'h3);
endmodule

//--- test/l2se_cpu_model.sv
// Purpose: management CPU side of the learn and delete message path
// Assumes: l2se_pkg compiled first
// Notes:   slow mode accepts a message only every fourth cycle
`timescale 1ns/100ps
module l2se_cpu_model (
  // clock and reset
  input  logic                CLK,
  input  logic                RESETN,
  // message path
  input  logic                slow,
  input  logic                msg_valid,
  input  l2se_pkg::l2se_msg_t msg,
  output logic                msg_ready,
  output l2se_pkg::l2se_msg_t last
);
  logic [1:0] tick;
  ////////////////////////////////////////////////////////////////////
  // accept pacing; a taken message is kept as the last one seen
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tick      <= 2'h0;
      msg_ready <= 1'b0;
      last      <= '0;
    end else begin
      tick      <= tick + 2'h1;
      msg_ready <= !slow || tick == 2'h3;
      if (msg_valid && msg_ready) begin
        last <= msg;
      end
    end
  end
endmodule

//--- test/test_l2_search_engine.sv
// Purpose: self-checking bench of the layer-2 search engine
// Assumes: l2se_pkg, l2se_cpu_model; short aging unit of 16 cycles
// Notes:   inputs change at the falling edge
`timescale 1ns/100ps
module test_l2_search_engine;
  logic                          CLK, RESETN, REQ_VALID, REQ_READY, RSP_VALID, slow;
  logic                          CPU_REPORT_EN, CPU_MSG_READY, CPU_MSG_VALID, CPU_POP;
  logic                          CPU_Q_VALID, CFG_WE, MAC_WE, VLAN_WE, TAG_MODE, PROT_EN;
  logic [511:0]                  REQ_DATA;
  logic [3:0]                    REQ_SRC, VLAN_WFLT;
  logic [9:0]                    REQ_CPU_DEST, VLAN_WMEM, PROT_PORTS;
  logic [1:0]                    CPU_Q_SEL;
  logic [11:0]                   CFG_ADDR, MAC_IDX, VLAN_WID;
  logic [7:0]                    CFG_WDATA, CFG_RDATA;
  logic [9:0][9:0]               PORT_MAP;
  logic [7:0][3:0][3:0]          TRUNK_MAP;
  l2se_pkg::l2se_rsp_t           RSP;
  l2se_pkg::l2se_msg_t           CPU_MSG, last;
  l2se_pkg::l2se_entry_t         MAC_ENTRY;
  l2se_pkg::l2se_flt_t [7:0]     PROTO_FLT, LPORT_FLT;
  l2se_pkg::l2se_rng_t           LPORT_RNG;
  int                            num_errors, tests_run;
  localparam logic [47:0] MA = 48'h00000a000001, MB = 48'h00000b000002;
  localparam logic [47:0] MC = 48'h00000c000003, MD = 48'h00000d000004;
  localparam logic [47:0] BC = 48'hffffffffffff, ME = 48'h00000e000005;

  l2se_top #(.AGE_UNIT_CYC(16)) u_l2se_top (.CLK(CLK), .RESETN(RESETN),
    .REQ_VALID(REQ_VALID), .REQ_DATA(REQ_DATA), .REQ_SRC(REQ_SRC),
    .REQ_CPU_DEST(REQ_CPU_DEST), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP(RSP), .CPU_REPORT_EN(CPU_REPORT_EN), .CPU_MSG_READY(CPU_MSG_READY),
    .CPU_MSG_VALID(CPU_MSG_VALID), .CPU_MSG(CPU_MSG), .CPU_POP(CPU_POP),
    .CPU_Q_VALID(CPU_Q_VALID), .CPU_Q_SEL(CPU_Q_SEL), .CFG_WE(CFG_WE),
    .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .MAC_WE(MAC_WE), .MAC_IDX(MAC_IDX), .MAC_ENTRY(MAC_ENTRY), .VLAN_WE(VLAN_WE),
    .VLAN_WID(VLAN_WID), .VLAN_WMEM(VLAN_WMEM), .VLAN_WFLT(VLAN_WFLT),
    .TAG_MODE(TAG_MODE), .PROT_EN(PROT_EN), .PROT_PORTS(PROT_PORTS),
    .PORT_MAP(PORT_MAP), .TRUNK_MAP(TRUNK_MAP), .PROTO_FLT(PROTO_FLT),
    .LPORT_FLT(LPORT_FLT), .LPORT_RNG(LPORT_RNG));
  l2se_cpu_model u_l2se_cpu_model (.CLK(CLK), .RESETN(RESETN), .slow(slow),
    .msg_valid(CPU_MSG_VALID), .msg(CPU_MSG), .msg_ready(CPU_MSG_READY), .last(last));

  ////////////////////////////////////////////////////////////////////
  // clock
  always #5 CLK = ~CLK;

  // compare and count
  task chk(input string n, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function logic [511:0] fr(input logic [47:0] da, sa, input logic [15:0] ty);
    return {da, sa, ty, 400'h0};
  endfunction
  function logic [511:0] tg(input logic [47:0] da, sa, input logic [2:0] p,
                            input logic [11:0] v);
    return {da, sa, 16'h8100, p, 1'b0, v, 384'h0};
  endfunction
  // one request, driven for one cycle once REQ_READY is high, then wait for its response pulse
  task req(input logic [3:0] s, input logic [511:0] d);
    int n;
    n = 0;
    @(negedge CLK);
    while (REQ_READY !== 1'b1) @(negedge CLK);
    REQ_SRC = s;
    REQ_DATA = d;
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    while (RSP_VALID !== 1'b1 && n < 300) begin
      @(negedge CLK);
      n++;
    end
    chk("rsp_valid", 1, RSP_VALID);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge CLK);
    CFG_ADDR = a;
    CFG_WDATA = d;
    CFG_WE = 1'b1;
    @(negedge CLK);
    CFG_WE = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge CLK);
    CFG_ADDR = a;
    @(negedge CLK);
    chk("cfg_rdata", e, CFG_RDATA);
  endtask
  task vl(input logic [11:0] id, input logic [9:0] m, input logic [3:0] f);
    @(negedge CLK);
    VLAN_WID = id;
    VLAN_WMEM = m;
    VLAN_WFLT = f;
    VLAN_WE = 1'b1;
    @(negedge CLK);
    VLAN_WE = 1'b0;
  endtask
  // direct table entry write, only between requests while the engine idles
  task mw(input logic [11:0] i, input l2se_pkg::l2se_entry_t en);
    @(negedge CLK);
    MAC_IDX = i;
    MAC_ENTRY = en;
    MAC_WE = 1'b1;
    @(negedge CLK);
    MAC_WE = 1'b0;
  endtask
  task pop;
    @(negedge CLK);
    CPU_POP = 1'b1;
    @(negedge CLK);
    CPU_POP = 1'b0;
    @(negedge CLK);
  endtask

  ////////////////////////////////////////////////////////////////////
  // scenarios
  task t_regs;
    rd(12'h400, 8'h2c);
    rd(12'h401, 8'h01);
    rd(12'h123, 8'h00);
    wr(12'h401, 8'h5a);
    rd(12'h401, 8'h5a);
    wr(12'h401, 8'h01);
    $display("regs done");
  endtask
  task t_learn;
    slow = 1'b1;
    req(4'h0, fr(MB, MA, 16'h0800));
    chk("flood", 1, RSP.flood);
    chk("dest", 10'h3fe, RSP.dest);
    repeat (12) @(negedge CLK);
    chk("learn_del", 0, last.del);
    chk("learn_mac", MA, last.mac);
    slow = 1'b0;
    req(4'h1, fr(MA, MC, 16'h0800));
    chk("dest", 10'h001, RSP.dest);
    chk("unicast", 1, RSP.unicast);
    chk("flood", 0, RSP.flood);
    $display("learn done");
  endtask
  task t_ports;
    REQ_CPU_DEST = 10'h010;
    req(4'h9, fr(MA, MD, 16'h0800));
    chk("cpu_dest", 10'h010, RSP.dest);
    PROT_EN = 1'b1;
    PROT_PORTS = 10'h003;
    req(4'h0, fr(BC, MA, 16'h0800));
    chk("prot_dest", 10'h3fc, RSP.dest);
    PROT_EN = 1'b0;
    TAG_MODE = 1'b0;
    PORT_MAP[0] = 10'h006;
    req(4'h0, fr(BC, MA, 16'h0800));
    chk("map_dest", 10'h006, RSP.dest);
    TAG_MODE = 1'b1;
    $display("ports done");
  endtask
  task t_filt;
    PROTO_FLT[0] = '{1'b1, 1'b1, 16'h0806};
    req(4'h2, fr(MA, MD, 16'h0806));
    chk("proto_discard", 1, RSP.discard);
    chk("proto_dest", 0, RSP.dest);
    PROTO_FLT[0] = '0;
    vl(12'h002, 10'h3ff, 4'h1);
    req(4'h2, tg(BC, MD, 3'h0, 12'h002));
    chk("vlan_discard", 1, RSP.discard);
    $display("filter done");
  endtask
  task t_cpuq;
    repeat (20) if (CPU_Q_VALID === 1'b1) pop;
    req(4'h3, tg(BC, MD, 3'h2, 12'h001));
    chk("cls4", 2'h1, RSP.cls4);
    chk("drop_prec", 1, RSP.drop_prec);
    req(4'h3, tg(BC, MD, 3'h7, 12'h001));
    chk("cls2", 1, RSP.cls2);
    repeat (2) @(negedge CLK);
    chk("q_sel", 2'h3, CPU_Q_SEL);
    pop;
    chk("q_sel", 2'h1, CPU_Q_SEL);
    pop;
    chk("q_valid", 0, CPU_Q_VALID);
    $display("cpu queue done");
  endtask
  // static trunk entry on the head of its chain, destination filter entry
  task t_mac;
    TRUNK_MAP[5][1] = 4'h6;
    mw(12'h02e, '{1'b1, 1'b1, 1'b1, 1'b0, 11'h000, MB, 10'h005, 1'b1, l2se_pkg::K_STATIC});
    mw(12'h03d, '{1'b1, 1'b1, 1'b1, 1'b0, 11'h000, ME, 10'h004, 1'b0, l2se_pkg::K_DFILT});
    req(4'h4, fr(MB, MC, 16'h0800));
    chk("trunk", 1, RSP.trunk);
    chk("trunk_no", 3'h5, RSP.trunk_no);
    chk("trunk_dest", 10'h040, RSP.dest);
    req(4'h4, fr(ME, MC, 16'h0800));
    chk("filt_discard", 1, RSP.discard);
    chk("filt_dest", 0, RSP.dest);
    $display("table done");
  endtask
  task t_age;
    int n;
    n = 0;
    // interval of 288 units: a whole scan pass must fit before the restart
    wr(12'h400, 8'h20);
    wr(12'h401, 8'h01);
    while (!(last.del === 1'b1 && last.mac === MA) && n < 30000) begin
      @(negedge CLK);
      n++;
    end
    chk("aged_mac", MA, last.mac);
    repeat (20) @(negedge CLK);
    req(4'h4, fr(MB, MC, 16'h0800));
    chk("static_kept", 1, RSP.trunk);
    $display("aging done");
  endtask

  task summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {CLK, RESETN, REQ_VALID, slow, CPU_POP, CFG_WE, MAC_WE, VLAN_WE, PROT_EN} = '0;
    {REQ_DATA, REQ_SRC, VLAN_WFLT, REQ_CPU_DEST, VLAN_WMEM, PROT_PORTS} = '0;
    {CFG_ADDR, MAC_IDX, VLAN_WID, CFG_WDATA, PORT_MAP, TRUNK_MAP} = '0;
    {MAC_ENTRY, PROTO_FLT, LPORT_FLT, LPORT_RNG, num_errors, tests_run} = '0;
    CPU_REPORT_EN = 1'b1;
    TAG_MODE = 1'b1;
    repeat (10) @(posedge CLK);
    @(negedge CLK);
    RESETN = 1'b1;
    vl(12'h001, 10'h3ff, 4'h0);
    t_regs;
    t_learn;
    t_ports;
    t_filt;
    t_cpuq;
    t_mac;
    t_age;
    summarize;
  end
  // watchdog
  initial begin
    #600000;
    num_errors++;
    summarize;
  end
endmodule
